// file: hw/ext_bus_pkg.sv
// package: constants, types and dram commands of the external bus wait and dram address block
package ext_bus_pkg;
	localparam int         ADDR_W         = 26;
	localparam int         DATA_W         = 32;
	localparam int         AREAS          = 8;
	localparam int         MUX_PINS       = 18;
	localparam int         ROW_BITS_BASE  = 11;
	localparam int         COL_BITS_BASE  = 8;
	localparam int         PRECHARGE_LINE = 10;
	localparam int         TOP_ADDR_BIT   = 25;
	localparam logic [2:0] AREA_2         = 3'h2;
	localparam logic [2:0] AREA_3         = 3'h3;
	localparam logic [2:0] AREA_4         = 3'h4;
	localparam logic [2:0] AREA_5A        = 3'h5;
	localparam logic [2:0] AREA_5B        = 3'h6;
	localparam logic [1:0] SIZE_BYTE      = 2'h0;
	localparam logic [1:0] SIZE_WORD      = 2'h1;
	localparam logic [1:0] SIZE_LONG      = 2'h2;
	localparam logic [1:0] BUS_8          = 2'h1;
	localparam logic [1:0] BUS_16         = 2'h2;
	localparam logic [1:0] BUS_32         = 2'h3;
	localparam logic [3:0] LANES_NONE     = 4'hf;
	localparam logic [7:0] SELECT_NONE    = 8'hff;
	// {ras_n, cas_n, rd_wr}; A10 splits precharge all/one and read/write with precharge,
	// CKE splits self from auto refresh
	localparam logic [2:0] CMD_NOP        = 3'h7;
	localparam logic [2:0] CMD_ACTIVATE   = 3'h3;
	localparam logic [2:0] CMD_READ       = 3'h5;
	localparam logic [2:0] CMD_WRITE      = 3'h4;
	localparam logic [2:0] CMD_PRECHARGE  = 3'h2;
	localparam logic [2:0] CMD_REFRESH    = 3'h1;
	localparam logic [2:0] CMD_MODE_SET   = 3'h0;

	typedef struct packed {
		logic [1:0] setup;
		logic [1:0] hold;
		logic [3:0] wait_rd;
		logic [3:0] wait_wr;
		logic       ext_wait_mask;
	} area_wait_t;

	typedef struct packed {
		logic [1:0] row_width_sel;
		logic [1:0] col_width_sel;
		logic       sdram_en;
	} sdram_cfg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [1:0]        size;
		logic [2:0]        area;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		bus_req_t   req;
		logic [3:0] wait_cnt;
		logic [1:0] setup;
		logic [1:0] hold;
		logic       ext_wait_mask;
		logic       sdram;
		logic       bus32;
		logic [1:0] row_sel;
		logic [1:0] col_sel;
		logic       pre;
		logic [3:0] lanes_n;
	} job_t;

	typedef struct packed {
		logic [7:0]        area_select_n;
		logic              rd_n;
		logic [3:0]        byte_enable_n;
		logic              bus_cycle_start_n;
		logic [ADDR_W-1:0] addr;
		logic              ras_n;
		logic              cas_n;
		logic              rd_wr;
	} pins_t;

	typedef enum logic [3:0] {
		ST_IDLE, ST_SETUP, ST_T1, ST_WAIT, ST_T2, ST_HOLD, ST_NOP, ST_ROW, ST_COL, ST_LAT
	} link_state_t;
endpackage

// file: hw/ext_bus_wait_sdram.sv
// external bus: normal-space wait/setup/hold sequencing and dram address multiplexing
`timescale 1ns/10ps
module ext_bus_wait_sdram
	import ext_bus_pkg::*;
(
	input  wire logic                    CLK,
	input  wire logic                    RST_B,
	input  wire logic                    BUS_CLK,
	output wire logic                    BUS_CLOCK_OUT,
	input  wire logic                    REQ_VALID,
	output wire logic                    REQ_READY,
	input  wire bus_req_t                REQ,
	input  wire area_wait_t [AREAS-1:0]  AREA_WAIT_CONTROL,
	input  wire logic [AREAS-1:0][1:0]   AREA_BUS_WIDTH,
	input  wire sdram_cfg_t [1:0]        SYNC_DRAM_CONTROL,
	input  wire logic                    AUTO_PRECHARGE,
	output logic                         RESP_VALID,
	output logic [DATA_W-1:0]            RESP_RDATA,
	output logic                         BUSY,
	input  wire logic                    WAIT_N,
	input  wire logic [DATA_W-1:0]       DATA_IN,
	output logic [DATA_W-1:0]            DATA_OUT,
	output logic                         DATA_OE,
	output pins_t                        BUS_PINS,
	output logic                         CKE
);

	function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic [1:0] size, input logic [1:0] width);
		logic [3:0] m;
		m = 4'h0;
		if (width == BUS_32) begin
			unique case (size)
				SIZE_BYTE: m = 4'h1 << a;
				SIZE_WORD: m = a[1] ? 4'hc : 4'h3;
				default:   m = 4'hf;
			endcase
		end else if (width == BUS_16) begin
			m = (size == SIZE_BYTE) ? (a[0] ? 4'h2 : 4'h1) : 4'h3;
		end else begin
			m = 4'h1;
		end
		return ~m;
	endfunction

	// bank pins sit right above the row field and carry the bank bits in both cycles
	function automatic logic [ADDR_W-1:0] mux_addr(input job_t j, input logic row_cycle);
		logic [ADDR_W-1:0] o;
		int                lo;
		int                col;
		int                row;
		int                idx;
		o   = j.req.addr;
		lo  = j.bus32 ? 2 : 1;
		col = COL_BITS_BASE + int'(j.col_sel);
		row = ROW_BITS_BASE + int'(j.row_sel);
		for (int k = 0; k < MUX_PINS; k++) begin
			idx = row_cycle ? k + col : k;
			if (idx > TOP_ADDR_BIT) begin
				idx = TOP_ADDR_BIT;
			end
			if (k >= lo + row && k <= lo + row + 1) begin
				idx = k + col;
			end
			o[k] = j.req.addr[idx];
		end
		if (!row_cycle) begin
			o[lo + PRECHARGE_LINE] = j.pre;
		end
		return o;
	endfunction

	assign BUS_CLOCK_OUT = BUS_CLK;

	// processor side
	job_t job_reg;
	job_t job_next;
	logic busy_reg;
	logic req_tgl_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic ack_seen_reg;
	logic ack_tgl_reg;
	logic [DATA_W-1:0] rdata_reg;
	area_wait_t        w_sel;
	logic              accept;

	assign REQ_READY = !busy_reg;
	assign accept    = REQ_VALID && !busy_reg;
	assign BUSY      = busy_reg;

	always_comb begin
		w_sel                  = AREA_WAIT_CONTROL[REQ.area];
		job_next.req           = REQ;
		job_next.setup         = w_sel.setup;
		job_next.hold          = w_sel.hold;
		job_next.ext_wait_mask = w_sel.ext_wait_mask;
		job_next.wait_cnt      = w_sel.wait_rd;
		if (REQ.write && (REQ.area == AREA_4 || REQ.area == AREA_5A || REQ.area == AREA_5B)) begin
			job_next.wait_cnt = w_sel.wait_wr;
		end
		job_next.sdram   = (REQ.area == AREA_2 || REQ.area == AREA_3) && SYNC_DRAM_CONTROL[REQ.area[0]].sdram_en;
		job_next.bus32   = AREA_BUS_WIDTH[REQ.area] == BUS_32;
		job_next.row_sel = SYNC_DRAM_CONTROL[REQ.area[0]].row_width_sel;
		job_next.col_sel = SYNC_DRAM_CONTROL[REQ.area[0]].col_width_sel;
		job_next.pre     = AUTO_PRECHARGE;
		job_next.lanes_n = lane_mask(REQ.addr[1:0], REQ.size, AREA_BUS_WIDTH[REQ.area]);
	end

	// job word stays still while busy, so the link may read it after the toggle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			job_reg     <= '0;
			req_tgl_reg <= 1'b0;
		end else if (accept) begin
			job_reg     <= job_next;
			req_tgl_reg <= !req_tgl_reg;
		end
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			ack_s1_reg   <= 1'b0;
			ack_s2_reg   <= 1'b0;
			ack_seen_reg <= 1'b0;
			busy_reg     <= 1'b0;
			RESP_VALID   <= 1'b0;
			RESP_RDATA   <= '0;
		end else begin
			ack_s1_reg   <= ack_tgl_reg;
			ack_s2_reg   <= ack_s1_reg;
			ack_seen_reg <= ack_s2_reg;
			RESP_VALID   <= ack_s2_reg != ack_seen_reg;
			if (ack_s2_reg != ack_seen_reg) begin
				busy_reg   <= 1'b0;
				RESP_RDATA <= rdata_reg;
			end else if (accept) begin
				busy_reg <= 1'b1;
			end
		end
	end

	// link side
	logic        lrst_s1_reg;
	logic        lrst_b;
	logic        req_s1_reg;
	logic        req_s2_reg;
	logic        req_seen_reg;
	logic        wait_s1_reg;
	logic        wait_s2_reg;
	logic        req_new;
	logic        take;
	logic        done;
	link_state_t state_reg;
	link_state_t state_next;
	logic [3:0]  cnt_reg;
	logic [3:0]  cnt_next;
	pins_t       pins_next;
	logic        oe_next;
	logic [7:0]  tw_reg;

	always_ff @(posedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			lrst_s1_reg <= 1'b0;
			lrst_b      <= 1'b0;
		end else begin
			lrst_s1_reg <= 1'b1;
			lrst_b      <= lrst_s1_reg;
		end
	end

	// first stage on the falling edge, second on the rising edge that decides
	always_ff @(negedge BUS_CLK or negedge lrst_b) begin
		if (!lrst_b) begin
			wait_s1_reg <= 1'b1;
		end else begin
			wait_s1_reg <= WAIT_N;
		end
	end

	always_ff @(posedge BUS_CLK or negedge lrst_b) begin
		if (!lrst_b) begin
			wait_s2_reg  <= 1'b1;
			req_s1_reg   <= 1'b0;
			req_s2_reg   <= 1'b0;
			req_seen_reg <= 1'b0;
		end else begin
			wait_s2_reg <= wait_s1_reg;
			req_s1_reg  <= req_tgl_reg;
			req_s2_reg  <= req_s1_reg;
			if (take) begin
				req_seen_reg <= req_s2_reg;
			end
		end
	end

	assign req_new = req_s2_reg != req_seen_reg;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		take       = 1'b0;
		done       = 1'b0;
		unique case (state_reg)
			ST_IDLE: begin
				if (req_new) begin
					take = 1'b1;
					if (job_reg.sdram) begin
						state_next = ST_ROW;
					end else if (job_reg.setup != 2'h0) begin
						state_next = ST_SETUP;
						cnt_next   = {2'h0, job_reg.setup};
					end else begin
						state_next = ST_T1;
						cnt_next   = job_reg.wait_cnt;
					end
				end
			end
			ST_SETUP: begin
				if (cnt_reg == 4'h1) begin
					state_next = ST_T1;
					cnt_next   = job_reg.wait_cnt;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_T1, ST_WAIT: begin
				if (cnt_reg != 4'h0) begin
					state_next = ST_WAIT;
					cnt_next   = cnt_reg - 4'h1;
				end else if (!job_reg.ext_wait_mask && !wait_s2_reg) begin
					state_next = ST_WAIT;
				end else begin
					state_next = ST_T2;
				end
			end
			// ack only in the last cycle: a new job may overwrite job_reg right after it
			ST_T2: begin
				if (job_reg.hold != 2'h0) begin
					state_next = ST_HOLD;
					cnt_next   = {2'h0, job_reg.hold};
				end else begin
					state_next = job_reg.ext_wait_mask ? ST_IDLE : ST_NOP;
					done       = job_reg.ext_wait_mask;
				end
			end
			ST_HOLD: begin
				if (cnt_reg == 4'h1) begin
					state_next = job_reg.ext_wait_mask ? ST_IDLE : ST_NOP;
					done       = job_reg.ext_wait_mask;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			ST_NOP: begin
				done       = 1'b1;
				state_next = ST_IDLE;
			end
			ST_ROW:  state_next = ST_COL;
			// one column command per access: burst length 1 in either write mode
			ST_COL:  state_next = ST_LAT;
			ST_LAT: begin
				done       = 1'b1;
				state_next = ST_IDLE;
			end
		endcase
	end

	always_comb begin
		pins_next                   = '0;
		pins_next.area_select_n     = SELECT_NONE;
		pins_next.rd_n              = 1'b1;
		pins_next.byte_enable_n     = LANES_NONE;
		pins_next.bus_cycle_start_n = 1'b1;
		pins_next.addr              = job_reg.req.addr;
		pins_next.ras_n             = 1'b1;
		pins_next.cas_n             = 1'b1;
		pins_next.rd_wr             = 1'b1;
		oe_next                     = 1'b0;
		unique case (state_next)
			ST_SETUP, ST_HOLD: begin
				pins_next.area_select_n = ~(8'h01 << job_reg.req.area);
				pins_next.rd_wr         = !job_reg.req.write;
				oe_next                 = job_reg.req.write;
			end
			ST_T1, ST_WAIT, ST_T2: begin
				pins_next.area_select_n     = ~(8'h01 << job_reg.req.area);
				pins_next.rd_wr             = !job_reg.req.write;
				pins_next.rd_n              = job_reg.req.write;
				pins_next.byte_enable_n     = job_reg.req.write ? job_reg.lanes_n : LANES_NONE;
				pins_next.bus_cycle_start_n = state_next != ST_T1;
				oe_next                     = job_reg.req.write;
			end
			ST_ROW: begin
				pins_next.area_select_n = ~(8'h01 << job_reg.req.area);
				{pins_next.ras_n, pins_next.cas_n, pins_next.rd_wr} = CMD_ACTIVATE;
				pins_next.addr          = mux_addr(job_reg, 1'b1);
			end
			ST_COL: begin
				pins_next.area_select_n = ~(8'h01 << job_reg.req.area);
				{pins_next.ras_n, pins_next.cas_n, pins_next.rd_wr} = job_reg.req.write ? CMD_WRITE : CMD_READ;
				pins_next.addr          = mux_addr(job_reg, 1'b0);
				pins_next.byte_enable_n = job_reg.lanes_n;
				oe_next                 = job_reg.req.write;
			end
			ST_IDLE, ST_NOP, ST_LAT: begin
				oe_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge BUS_CLK or negedge lrst_b) begin
		if (!lrst_b) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 4'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	always_ff @(posedge BUS_CLK or negedge lrst_b) begin
		if (!lrst_b) begin
			BUS_PINS                   <= '0;
			BUS_PINS.area_select_n     <= SELECT_NONE;
			BUS_PINS.rd_n              <= 1'b1;
			BUS_PINS.byte_enable_n     <= LANES_NONE;
			BUS_PINS.bus_cycle_start_n <= 1'b1;
			BUS_PINS.ras_n             <= 1'b1;
			BUS_PINS.cas_n             <= 1'b1;
			BUS_PINS.rd_wr             <= 1'b1;
			DATA_OE                    <= 1'b0;
			DATA_OUT                   <= '0;
			CKE                        <= 1'b0;
		end else begin
			BUS_PINS <= pins_next;
			DATA_OE  <= oe_next;
			DATA_OUT <= job_reg.req.wdata;
			CKE      <= 1'b1;
		end
	end

	// data taken at the end of T2 or latency, held until the next access reaches that point
	always_ff @(posedge BUS_CLK or negedge lrst_b) begin
		if (!lrst_b) begin
			rdata_reg   <= '0;
			ack_tgl_reg <= 1'b0;
		end else begin
			if (state_reg == ST_T2 || state_reg == ST_LAT) begin
				rdata_reg <= DATA_IN;
			end
			if (done) begin
				ack_tgl_reg <= !ack_tgl_reg;
			end
		end
	end

	always_ff @(posedge BUS_CLK or negedge lrst_b) begin
		if (!lrst_b) begin
			tw_reg <= 8'h0;
		end else if (state_reg == ST_T1) begin
			tw_reg <= 8'h0;
		end else if (state_reg == ST_WAIT) begin
			tw_reg <= tw_reg + 8'h1;
		end
	end

	a_wait_exact: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_T2 && job_reg.ext_wait_mask) |-> tw_reg == {4'h0, job_reg.wait_cnt})
		else $error("software wait count not met");
	a_wait_select: assert property (@(posedge CLK) disable iff (!RST_B)
		(accept && REQ.area == 3'h1 && REQ.write) |=> job_reg.wait_cnt == $past(AREA_WAIT_CONTROL[1].wait_rd))
		else $error("shared wait setting not used");
	a_ext_wait_hold: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		((state_reg == ST_T1 || state_reg == ST_WAIT) && cnt_reg == 4'h0 && !job_reg.ext_wait_mask && !wait_s2_reg)
		|=> state_reg == ST_WAIT)
		else $error("external wait not honoured");
	a_mask_no_idle: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_T2 && job_reg.hold == 2'h0 && job_reg.ext_wait_mask) |=> state_reg == ST_IDLE)
		else $error("idle cycle inserted with wait masked");
	a_two_cycle: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_T1 && cnt_reg == 4'h0 && job_reg.ext_wait_mask) |=> state_reg == ST_T2 ##1 state_reg != ST_T2)
		else $error("no-wait access not two cycles");
	a_setup_strobes: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_SETUP || state_reg == ST_HOLD)
		|-> BUS_PINS.rd_n && BUS_PINS.byte_enable_n == LANES_NONE && BUS_PINS.area_select_n != SELECT_NONE)
		else $error("strobe active in setup or hold");
	a_hold_data: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_HOLD && job_reg.req.write) |-> DATA_OE)
		else $error("write data dropped in hold");
	a_upper_addr: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_ROW || state_reg == ST_COL) |-> BUS_PINS.addr[25:18] == job_reg.req.addr[25:18])
		else $error("upper address multiplexed");
	a_row_map: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_ROW && job_reg.bus32 && job_reg.row_sel == 2'h0 && job_reg.col_sel == 2'h0)
		|-> BUS_PINS.addr[16:0] == job_reg.req.addr[24:8] && BUS_PINS.addr[17] == job_reg.req.addr[25])
		else $error("row address map wrong");
	a_col_precharge: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_COL) |-> BUS_PINS.addr[job_reg.bus32 ? 12 : 11] == job_reg.pre
		&& $past(state_reg) == ST_ROW)
		else $error("precharge level wrong");
	a_long_lanes: assert property (@(posedge BUS_CLK) disable iff (!lrst_b)
		(state_reg == ST_COL && job_reg.bus32 && job_reg.req.size == SIZE_LONG) |-> BUS_PINS.byte_enable_n == 4'h0)
		else $error("longword lanes masked");

endmodule

// file: tb/bus_far_side_model.sv
// far side model: static memory or dram answering on the data pins, slow device pulling wait
`timescale 1ns/10ps
module bus_far_side_model
	import ext_bus_pkg::*;
#(
	parameter logic [DATA_W-1:0] READ_VAL = 32'h5a3c_96e1
)
(
	input  wire logic              BUS_CLK,
	input  wire logic              RST_B,
	input  wire pins_t             PINS,
	input  wire logic [3:0]        WAIT_HOLD,
	output logic                   WAIT_N,
	output logic [DATA_W-1:0]      DATA_IN
);
	logic [3:0] held_reg;
	logic       lat_reg;

	// dram read data one cycle after the column command
	always_ff @(posedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			lat_reg <= 1'b0;
		end else begin
			lat_reg <= !PINS.cas_n && PINS.rd_wr;
		end
	end

	// wait pulled low one cycle after select, so the synchroniser delay must be covered by setup or wait cycles
	always_ff @(posedge BUS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			held_reg <= 4'h0;
			WAIT_N   <= 1'b1;
		end else if (PINS.area_select_n == SELECT_NONE) begin
			held_reg <= 4'h0;
			WAIT_N   <= 1'b1;
		end else if (held_reg < WAIT_HOLD) begin
			held_reg <= held_reg + 4'h1;
			WAIT_N   <= 1'b0;
		end else begin
			WAIT_N <= 1'b1;
		end
	end

	// undriven bus shows the inverse, so a late capture cannot match by luck
	assign DATA_IN = (!PINS.rd_n || lat_reg) ? READ_VAL : ~READ_VAL;
endmodule

// file: tb/ext_bus_wait_and_sdram_addr_mux_tb.sv
// testbench: wait, setup/hold sequencing and dram address multiplexing
`timescale 1ns/10ps
module ext_bus_wait_and_sdram_addr_mux_tb;
	import ext_bus_pkg::*;
	localparam logic [DATA_W-1:0] READ_VAL = 32'h5a3c_96e1;
	logic                   clk = 1'b0;
	logic                   bus_clk = 1'b0;
	logic                   rst_b = 1'b0;
	logic                   req_valid = 1'b0;
	logic                   req_ready;
	bus_req_t               req = '0;
	area_wait_t [AREAS-1:0] wcfg = '0;
	logic [AREAS-1:0][1:0]  width = {AREAS{BUS_32}};
	sdram_cfg_t [1:0]       dcfg = '0;
	logic                   ap = 1'b0;
	logic                   resp_valid;
	logic [DATA_W-1:0]      resp_rdata;
	logic                   wait_n;
	logic [DATA_W-1:0]      data_in;
	logic                   data_oe;
	logic                   bus_clk_out;
	logic                   busy;
	logic                   cke;
	logic [DATA_W-1:0]      data_out;
	logic [DATA_W-1:0]      wd_seen;
	pins_t                  pins;
	logic [3:0]             hold_req = 4'h0;
	int                     err_count = 0;
	int                     n_checks = 0;
	int                     pre, str, post, oe_post;
	logic [3:0]             be_seen, col_mask;
	logic [ADDR_W-1:0]      row_a, col_a;
	logic [2:0]             row_cmd, col_cmd;
	logic [7:0]             sel_seen;
	logic [DATA_W-1:0]      rdata;

	initial begin
		forever #2 clk = ~clk;
	end
	initial begin
		#3.3;
		forever #7.5 bus_clk = ~bus_clk;
	end

	ext_bus_wait_sdram uut (
		.CLK(clk), .RST_B(rst_b), .BUS_CLK(bus_clk), .BUS_CLOCK_OUT(bus_clk_out), .REQ_VALID(req_valid),
		.REQ_READY(req_ready), .REQ(req), .AREA_WAIT_CONTROL(wcfg), .AREA_BUS_WIDTH(width),
		.SYNC_DRAM_CONTROL(dcfg), .AUTO_PRECHARGE(ap), .RESP_VALID(resp_valid), .RESP_RDATA(resp_rdata),
		.BUSY(busy), .WAIT_N(wait_n), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe), .BUS_PINS(pins),
		.CKE(cke)
	);

	bus_far_side_model #(.READ_VAL(READ_VAL)) far (
		.BUS_CLK(bus_clk), .RST_B(rst_b), .PINS(pins), .WAIT_HOLD(hold_req), .WAIT_N(wait_n), .DATA_IN(data_in)
	);

	// pin monitor: splits each select period into setup, strobe and hold cycles
	always @(posedge bus_clk) begin
		#1;
		if (data_oe === 1'b1) wd_seen = data_out;
		if (pins.area_select_n != SELECT_NONE) begin
			if (!pins.rd_n || pins.byte_enable_n != LANES_NONE) begin
				str++;
				be_seen = pins.byte_enable_n;
			end else if (str == 0) begin
				pre++;
			end else begin
				post++;
				if (data_oe === 1'b1) oe_post++;
			end
			if (pins.ras_n === 1'b0) begin
				row_a    = pins.addr;
				row_cmd  = {pins.ras_n, pins.cas_n, pins.rd_wr};
				sel_seen = pins.area_select_n;
			end
			if (pins.cas_n === 1'b0) begin
				col_a    = pins.addr;
				col_cmd  = {pins.ras_n, pins.cas_n, pins.rd_wr};
				col_mask = pins.byte_enable_n;
			end
		end
	end

	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task access(input logic [2:0] area, input logic wr, input logic [1:0] size, input logic [ADDR_W-1:0] a);
		int i;
		pre = 0;
		str = 0;
		post = 0;
		oe_post = 0;
		row_a = '0;
		col_a = '0;
		wd_seen = '0;
		@(posedge clk);
		#1;
		chk("ready", req_ready, 1'b1);
		req = '{addr: a, write: wr, size: size, area: area, wdata: 32'hc35a_0f96};
		req_valid = 1'b1;
		@(posedge clk);
		#1;
		req_valid = 1'b0;
		chk("busy", busy, 1'b1);
		chk("ready low", req_ready, 1'b0);
		for (i = 0; i < 600; i++) begin
			@(posedge clk);
			#1;
			if (resp_valid === 1'b1) break;
		end
		if (i == 600) begin
			err_count++;
			end_sim;
		end
		rdata = resp_rdata;
		chk("busy cleared", busy, 1'b0);
	endtask

	function automatic logic [ADDR_W-1:0] exp_row(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] r;
		r = a;
		for (int k = 0; k < 17; k++) r[k] = a[k+8];
		r[17] = a[25];
		return r;
	endfunction

	task s_normal_wait;
		int w;
		for (int k = 0; k < 2; k++) begin
			w = k * 15;
			wcfg[1] = '{setup: 2'h1, hold: 2'h2, wait_rd: w[3:0], wait_wr: 4'h9, ext_wait_mask: 1'b1};
			access(3'h1, 1'b0, SIZE_LONG, 26'h000_1230);
			chk("strobe cycles", str, 2 + w);
			chk("setup cycles", pre, 1);
			chk("hold cycles", post, 2);
			chk("read data", rdata, READ_VAL);
		end
		access(3'h1, 1'b1, SIZE_LONG, 26'h000_1230);
		chk("shared wait", str, 17);
	endtask

	task s_split_wait;
		for (int a = 4; a < 7; a++) begin
			wcfg[a] = '{setup: 2'h0, hold: 2'h1, wait_rd: 4'h1, wait_wr: 4'h5, ext_wait_mask: 1'b1};
			access(a[2:0], 1'b1, SIZE_BYTE, 26'h010_0042);
			chk("write wait", str, 7);
			chk("data in hold", oe_post, 1);
			chk("write data", wd_seen, 32'hc35a_0f96);
			chk("write lanes", be_seen, 4'hb);
			access(a[2:0], 1'b0, SIZE_LONG, 26'h010_0040);
			chk("read wait", str, 3);
		end
	endtask

	task s_ext_wait;
		// long setup so the slow device has wait low before the sampling edge
		wcfg[0] = '{setup: 2'h2, hold: 2'h0, wait_rd: 4'h0, wait_wr: 4'h0, ext_wait_mask: 1'b1};
		hold_req = 4'h6;
		access(3'h0, 1'b0, SIZE_LONG, 26'h000_0100);
		chk("masked wait", str, 2);
		wcfg[0].ext_wait_mask = 1'b0;
		access(3'h0, 1'b0, SIZE_LONG, 26'h000_0100);
		chk("wait extends", str > 2, 1'b1);
		chk("read data", rdata, READ_VAL);
		hold_req = 4'h0;
	endtask

	task s_dram;
		logic [ADDR_W-1:0] a;
		logic [ADDR_W-1:0] c;
		a = 26'h3a5_b6c4;
		width[2] = BUS_32;
		dcfg[0] = '{row_width_sel: 2'h0, col_width_sel: 2'h0, sdram_en: 1'b1};
		ap = 1'b1;
		access(AREA_2, 1'b1, SIZE_LONG, a);
		c = a;
		c[12] = 1'b1;
		c[13] = a[21];
		c[14] = a[22];
		chk("row address", row_a, exp_row(a));
		chk("column address", col_a, c);
		chk("row command", row_cmd, CMD_ACTIVATE);
		chk("column command", col_cmd, CMD_WRITE);
		chk("write masks", col_mask, 4'h0);
		chk("dram write data", wd_seen, 32'hc35a_0f96);
		chk("dram select", sel_seen, 8'hfb);
		width[3] = BUS_16;
		dcfg[1] = '{row_width_sel: 2'h0, col_width_sel: 2'h0, sdram_en: 1'b1};
		ap = 1'b0;
		access(AREA_3, 1'b0, SIZE_WORD, a);
		chk("precharge pin", col_a[11], 1'b0);
		chk("upper pins", col_a[25:18], a[25:18]);
		chk("upper row pins", row_a[25:18], a[25:18]);
		chk("column command", col_cmd, CMD_READ);
		chk("dram select", sel_seen, 8'hf7);
		chk("dram read data", rdata, READ_VAL);
	endtask

	initial begin
		// four clocks of reset; a link edge falls inside it and clears the reset sync
		repeat (4) @(posedge clk);
		#1;
		chk("clock enable in reset", cke, 1'b0);
		rst_b = 1'b1;
		@(posedge bus_clk);
		#1;
		chk("bus clock out", bus_clk_out, 1'b1);
		repeat (10) @(posedge clk);
		#1;
		chk("clock enable", cke, 1'b1);
		s_normal_wait;
		s_split_wait;
		s_ext_wait;
		s_dram;
		end_sim;
	end
endmodule
